// ===== pkg/acmt_pkg.sv
// Shared constants for the sampling converter control block
package acmt_pkg;
    localparam int unsigned AIN_W       = 12;   // Width of a digitised analog level
    localparam int unsigned CODE_W      = 10;   // Result width, straight binary
    localparam int unsigned NUM_CODES   = 1024; // Evenly spaced output codes
    localparam int unsigned COARSE_W    = 5;    // Bits settled by the coarse stage
    localparam int unsigned FINE_W      = 5;    // Bits settled by the fine stage
    localparam int unsigned NUM_CH      = 8;    // Multiplexer inputs
    localparam int unsigned CH_W        = 3;    // Channel number width
    localparam int unsigned FIFO_DEPTH  = 8;    // Result buffer depth
    localparam int unsigned CONV_PERIODS = 2;   // Conversion clock periods per result
    localparam logic [CODE_W-1:0] CODE_ZERO = 10'h000;
    localparam logic [CODE_W-1:0] CODE_FULL = 10'h3FF;
    localparam logic [CH_W-1:0]   CH_RESET  = 3'h0;
    // Result word pushed into the buffer: overflow flag above the code
    localparam int unsigned WORD_W = CODE_W + 1;
    typedef enum logic {ACMT_PH_SAMPLE, ACMT_PH_BALANCE} acmt_phase_t;
endpackage : acmt_pkg

// ===== design/acmt_fifo.sv
// Result buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module acmt_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             i_clk,      // System clock
    input  wire logic             i_rst_n,    // Synchronised reset, active low
    input  wire logic             i_in_valid, // Word offered
    output logic                  o_in_ready, // Room for a word
    input  wire logic [WIDTH-1:0] i_in_data,  // Word in
    output logic                  o_out_valid,// Word available
    input  wire logic             i_out_ready,// Drain side takes word
    output logic      [WIDTH-1:0] o_out_data  // Oldest word
);
    localparam int unsigned IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [IW-1:0] LAST_C  = IW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [IW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0]    cnt_q, cnt_d;
    logic             push, pop;

    assign o_in_ready  = (cnt_q != DEPTH_C);
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rd_q];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = i_in_data;
            wr_d        = (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : acmt_fifo
`default_nettype wire

// ===== design/acmt_core.sv
// Two-step converter timing model with channel multiplexer and result buffer
`timescale 1ns/10ps
`default_nettype none
module acmt_core
    import acmt_pkg::*;
#(
    parameter int unsigned AW    = AIN_W,     // Analog level width
    parameter int unsigned DEPTH = FIFO_DEPTH // Result buffer depth
) (
    input  wire logic                   i_clk_sys,         // 200 MHz system clock
    input  wire logic                   i_rst_n,           // Reset, active low, async
    input  wire logic                   i_conv_clk,        // Conversion clock pin
    input  wire logic                   i_wr_n,            // Channel write strobe, active low
    input  wire logic                   i_channel_sel_bit2,// Channel address bit 2
    input  wire logic                   i_channel_sel_bit1,// Channel address bit 1
    input  wire logic                   i_channel_sel_bit0,// Channel address bit 0
    input  wire logic [NUM_CH-1:0][AW-1:0] i_ain,          // Digitised channel levels
    input  wire logic [AW-1:0]          i_ref_lo,          // Lower reference level
    input  wire logic [AW-1:0]          i_overflow_threshold, // Upper reference level
    output logic      [CODE_W-1:0]      o_data,            // Result code pins
    output logic                        o_overflow,        // Overflow flag pin
    output logic      [CH_W-1:0]        o_channel,         // Channel now routed
    output logic                        o_conv_drop,       // Sample lost to a full buffer
    output logic                        o_strm_valid,      // Buffered result available
    input  wire logic                   i_strm_ready,      // Consumer takes result
    output logic      [CODE_W-1:0]      o_strm_data,       // Buffered result code
    output logic                        o_strm_overflow    // Buffered overflow flag
);
    // Reset release and pin synchronisers
    logic       rst_s1_q, rst_n_s;
    logic [5:0] pin_s1_q, pin_s2_q;
    logic       ck_prev_q;
    logic [NUM_CH-1:0][AW-1:0] ain_s1_q, ain_s2_q;
    logic [AW-1:0] lo_s1_q, lo_s2_q, hi_s1_q, hi_s2_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_s  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_s  <= rst_s1_q;
        end
    end

    // Clock idles high between bursts, so reset the clock and strobe copies to high
    always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pin_s1_q  <= 6'h3;
            pin_s2_q  <= 6'h3;
            ck_prev_q <= 1'b1;
            ain_s1_q  <= '0;
            ain_s2_q  <= '0;
            lo_s1_q   <= '0;
            lo_s2_q   <= '0;
            hi_s1_q   <= '0;
            hi_s2_q   <= '0;
        end else begin
            pin_s1_q  <= {i_channel_sel_bit2, i_channel_sel_bit1, i_channel_sel_bit0,
                          1'b0, i_wr_n, i_conv_clk};
            pin_s2_q  <= pin_s1_q;
            ck_prev_q <= pin_s2_q[0];
            ain_s1_q  <= i_ain;
            ain_s2_q  <= ain_s1_q;
            lo_s1_q   <= i_ref_lo;
            lo_s2_q   <= lo_s1_q;
            hi_s1_q   <= i_overflow_threshold;
            hi_s2_q   <= hi_s1_q;
        end
    end

    logic            ck_s, wr_n_s, ck_rise, ck_fall;
    logic [CH_W-1:0] addr_s;
    assign ck_s    = pin_s2_q[0];
    assign wr_n_s  = pin_s2_q[1];
    assign addr_s  = pin_s2_q[5:3];
    assign ck_rise = ck_s & ~ck_prev_q;
    assign ck_fall = ~ck_s & ck_prev_q;

    // Ladder span; an inverted reference pair collapses to zero span
    logic [AW-1:0] span;
    assign span = (hi_s2_q > lo_s2_q) ? (hi_s2_q - lo_s2_q) : '0;

    // Ladder tap at code index k: lo + span*k/1024
    function automatic logic [AW:0] tap(input logic [AW-1:0] lo, input logic [AW-1:0] sp,
                                        input logic [CODE_W-1:0] k);
        logic [AW+CODE_W-1:0] prod;
        prod = sp * k;
        return {1'b0, lo} + {1'b0, prod[AW+CODE_W-1:CODE_W]};
    endfunction : tap

    // State
    acmt_phase_t              phase_q, phase_d;
    logic [CH_W-1:0]          chan_q, chan_d, pend_q, pend_d;
    logic                     wr_prev_q, wr_prev_d;
    logic [AW-1:0]            smp_q, smp_d;
    logic [COARSE_W-1:0]      crs_q, crs_d;
    logic                     under_q, under_d, over_q, over_d, smp_vld_q, smp_vld_d;
    logic [CODE_W-1:0]        st1_q, st1_d, out_q, out_d;
    logic                     st1_ovf_q, st1_ovf_d, st1_vld_q, st1_vld_d;
    logic                     out_ovf_q, out_ovf_d, push_q, push_d, drop_q, drop_d;
    logic                     fifo_ready, stall;
    logic [AW-1:0]            ain_sel;
    logic [COARSE_W-1:0]      crs_new;
    logic [FINE_W-1:0]        fine_new;

    assign ain_sel = ain_s2_q[chan_q];
    // Buffer back-pressure freezes the whole pipeline
    assign stall   = push_q & ~fifo_ready;

    // Coarse range from the sample being captured
    always_comb begin
        crs_new = '0;
        for (int k = 1; k < (1 << COARSE_W); k++) begin
            if ({1'b0, ain_sel} >= tap(lo_s2_q, span, CODE_W'(k << FINE_W))) begin
                crs_new = COARSE_W'(k);
            end
        end
    end

    // Fine resolution inside the held range
    always_comb begin
        fine_new = '0;
        for (int j = 1; j < (1 << FINE_W); j++) begin
            if ({1'b0, smp_q} >= tap(lo_s2_q, span, {crs_q, FINE_W'(j)})) begin
                fine_new = FINE_W'(j);
            end
        end
    end

    always_comb begin
        phase_d   = phase_q;
        chan_d    = chan_q;
        pend_d    = pend_q;
        wr_prev_d = wr_n_s;
        smp_d     = smp_q;
        crs_d     = crs_q;
        under_d   = under_q;
        over_d    = over_q;
        smp_vld_d = smp_vld_q;
        st1_d     = st1_q;
        st1_ovf_d = st1_ovf_q;
        st1_vld_d = st1_vld_q;
        out_d     = out_q;
        out_ovf_d = out_ovf_q;
        push_d    = push_q & ~fifo_ready;
        drop_d    = 1'b0;
        // Follow the address while strobe low, route it at release
        if (!wr_n_s) begin
            pend_d = addr_s;
        end
        // New channel takes effect on strobe rising
        if (wr_n_s && !wr_prev_q) begin
            chan_d = pend_q;
        end
        if (ck_rise) begin
            phase_d = ACMT_PH_BALANCE;
            if (stall) begin
                drop_d = 1'b1;
            end else begin
                // Rising edge closes the sampling phase
                smp_d     = ain_sel;
                crs_d     = crs_new;
                under_d   = (ain_sel < lo_s2_q);
                over_d    = (ain_sel >= hi_s2_q);
                smp_vld_d = 1'b1;
                // Second stage loads from the first
                if (st1_vld_q) begin
                    out_d     = st1_q;
                    out_ovf_d = st1_ovf_q;
                    push_d    = 1'b1;
                    st1_vld_d = 1'b0;
                end
            end
        end
        if (ck_fall) begin
            phase_d = ACMT_PH_SAMPLE;
            // Fine result ready at end of balance, out at next rise
            if (smp_vld_q && !stall) begin
                smp_vld_d = 1'b0;
                st1_vld_d = 1'b1;
                // Flag kept apart from the code
                st1_ovf_d = over_q;
                if (under_q) begin
                    st1_d = CODE_ZERO;
                end else if (over_q) begin
                    st1_d = CODE_FULL;
                end else begin
                    // Straight binary of coarse and fine
                    st1_d = {crs_q, fine_new};
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
            phase_q   <= ACMT_PH_BALANCE;
            chan_q    <= CH_RESET;
            pend_q    <= CH_RESET;
            wr_prev_q <= 1'b1;
            smp_q     <= '0;
            crs_q     <= '0;
            under_q   <= 1'b0;
            over_q    <= 1'b0;
            smp_vld_q <= 1'b0;
            st1_q     <= CODE_ZERO;
            st1_ovf_q <= 1'b0;
            st1_vld_q <= 1'b0;
            out_q     <= CODE_ZERO;
            out_ovf_q <= 1'b0;
            push_q    <= 1'b0;
            drop_q    <= 1'b0;
        end else begin
            phase_q   <= phase_d;
            chan_q    <= chan_d;
            pend_q    <= pend_d;
            wr_prev_q <= wr_prev_d;
            smp_q     <= smp_d;
            crs_q     <= crs_d;
            under_q   <= under_d;
            over_q    <= over_d;
            smp_vld_q <= smp_vld_d;
            st1_q     <= st1_d;
            st1_ovf_q <= st1_ovf_d;
            st1_vld_q <= st1_vld_d;
            out_q     <= out_d;
            out_ovf_q <= out_ovf_d;
            push_q    <= push_d;
            drop_q    <= drop_d;
        end
    end

    assign o_data      = out_q;
    assign o_overflow  = out_ovf_q;
    assign o_channel   = chan_q;
    assign o_conv_drop = drop_q;

    logic [WORD_W-1:0] strm_word;

    acmt_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_clk       (i_clk_sys),
        .i_rst_n     (rst_n_s),
        .i_in_valid  (push_q),
        .o_in_ready  (fifo_ready),
        .i_in_data   ({out_ovf_q, out_q}),
        .o_out_valid (o_strm_valid),
        .i_out_ready (i_strm_ready),
        .o_out_data  (strm_word)
    );

    assign o_strm_data     = strm_word[CODE_W-1:0];
    assign o_strm_overflow = strm_word[CODE_W];
endmodule : acmt_core
`default_nettype wire

// ===== test/acmt_core_sva.sv
// Port-level assertions for the converter control block
`timescale 1ns/10ps
`default_nettype none
module acmt_core_sva
    import acmt_pkg::*;
(
    input wire logic              i_clk_sys,          // System clock
    input wire logic              i_rst_n,            // Reset, active low
    input wire logic              i_conv_clk,         // Conversion clock pin
    input wire logic              i_wr_n,             // Channel strobe
    input wire logic              i_channel_sel_bit2, // Address bit 2
    input wire logic              i_channel_sel_bit1, // Address bit 1
    input wire logic              i_channel_sel_bit0, // Address bit 0
    input wire logic              i_strm_ready,       // Consumer ready
    input wire logic [CODE_W-1:0] o_data,             // Result code
    input wire logic              o_overflow,         // Overflow flag
    input wire logic [CH_W-1:0]   o_channel,          // Routed channel
    input wire logic              o_conv_drop,        // Dropped sample
    input wire logic              o_strm_valid,       // Buffer not empty
    input wire logic [CODE_W-1:0] o_strm_data,        // Buffered code
    input wire logic              o_strm_overflow     // Buffered flag
);
    logic [CH_W-1:0] addr_q;
    logic [CH_W-1:0] addr_d;

    // Address last seen under a low strobe
    always_comb addr_d = i_wr_n ? addr_q
                                : {i_channel_sel_bit2, i_channel_sel_bit1, i_channel_sel_bit0};
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) addr_q <= CH_RESET;
        else addr_q <= addr_d;
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence s_wr_done;
        !i_wr_n ##1 i_wr_n;
    endsequence
    // Pin rose within the last few cycles; sync lag is far below a phase
    sequence s_rise_recent;
        $past(i_conv_clk, 1) && !$past(i_conv_clk, 10);
    endsequence

    AST_CH_UPD: assert property (s_wr_done |-> ##[1:6] o_channel == addr_q)
        else $error("routed channel differs from strobed address");
    AST_CH_HOLD: assert property (i_wr_n [*8] |=> $stable(o_channel))
        else $error("channel moved without a strobe");
    AST_DATA_RISE: assert property ($changed(o_data) |-> s_rise_recent)
        else $error("result changed away from a clock rise");
    AST_PUSH: assert property ($changed(o_data) |-> ##[0:2] o_strm_valid)
        else $error("new result not offered on the stream");
    AST_DROP_RISE: assert property (o_conv_drop |-> s_rise_recent ##0 o_strm_valid)
        else $error("drop pulse without a rise on a busy buffer");
    AST_DROP_PULSE: assert property (o_conv_drop |=> !o_conv_drop)
        else $error("drop pulse longer than one cycle");
    AST_OVF_FULL: assert property (o_overflow |-> o_data == CODE_FULL)
        else $error("overflow without full scale code");
    AST_STRM_OVF: assert property (o_strm_valid && o_strm_overflow |-> o_strm_data == CODE_FULL)
        else $error("buffered overflow without full scale code");
    AST_STRM_HOLD: assert property (o_strm_valid && !i_strm_ready |=>
        o_strm_valid && $stable(o_strm_data) && $stable(o_strm_overflow))
        else $error("stalled stream word changed");
endmodule : acmt_core_sva

bind acmt_core acmt_core_sva u_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_conv_clk(i_conv_clk), .i_wr_n(i_wr_n), .i_channel_sel_bit2(i_channel_sel_bit2),
    .i_channel_sel_bit1(i_channel_sel_bit1), .i_channel_sel_bit0(i_channel_sel_bit0),
    .i_strm_ready(i_strm_ready), .o_data(o_data), .o_overflow(o_overflow),
    .o_channel(o_channel), .o_conv_drop(o_conv_drop), .o_strm_valid(o_strm_valid),
    .o_strm_data(o_strm_data), .o_strm_overflow(o_strm_overflow));
`default_nettype wire

// ===== test/acmt_host_model.sv
// Host controller model: conversion clock, channel address and strobe
`timescale 1ns/10ps
`default_nettype none
module acmt_host_model
    import acmt_pkg::*;
#(
    parameter int MIN_LOW    = 25, // min_clock_low_time in system cycles
    parameter int MIN_HIGH   = 25, // Minimum high time in system cycles
    parameter int MIN_PERIOD = 100 // Minimum conversion period in system cycles
) (
    input  wire logic            i_clk,      // System clock
    output logic                 o_conv_clk, // Conversion clock
    output logic                 o_wr_n,     // Strobe, active low
    output logic      [CH_W-1:0] o_sel       // Channel address
);
    // Parked high, balanced and ready to sample
    initial begin
        o_conv_clk = 1'b1;
        o_wr_n = 1'b1;
        o_sel = '0;
    end

    // Any duty, low never below the minimum
    task automatic pulse(input int lo, input int hi);
        int lo_n;
        int hi_n;
        lo_n = (lo < MIN_LOW) ? MIN_LOW : lo;
        hi_n = (hi < MIN_HIGH) ? MIN_HIGH : hi;
        // Stretch the high phase so a short low never breaks the period
        if (lo_n + hi_n < MIN_PERIOD) begin
            hi_n = MIN_PERIOD - lo_n;
        end
        @(posedge i_clk) o_conv_clk <= 1'b0;
        repeat (lo_n) @(posedge i_clk);
        o_conv_clk <= 1'b1;
        repeat (hi_n) @(posedge i_clk);
    endtask : pulse

    // Address set up, strobe pulsed low, then released
    task automatic write_ch(input logic [CH_W-1:0] ch);
        @(posedge i_clk) o_sel <= ch;
        repeat (16) @(posedge i_clk);
        o_wr_n <= 1'b0;
        repeat (8) @(posedge i_clk);
        o_wr_n <= 1'b1;
        // Address pins have pull-downs once released
        @(posedge i_clk) o_sel <= '0;
        repeat (8) @(posedge i_clk);
    endtask : write_ch
endmodule : acmt_host_model
`default_nettype wire

// ===== test/adc_sample_convert_mux_timing_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_sample_convert_mux_timing_tb_top;
    import acmt_pkg::*;
    logic                          clk;
    logic                          rst_n;
    logic                          rdy;
    logic                          conv_clk;
    logic                          wr_n;
    logic [CH_W-1:0]               sel;
    logic [NUM_CH-1:0][AIN_W-1:0]  ain;
    logic [AIN_W-1:0]              ref_lo;
    logic [AIN_W-1:0]              ref_hi;
    logic [CODE_W-1:0]             o_data;
    logic [CODE_W-1:0]             o_strm_data;
    logic [CH_W-1:0]               o_channel;
    logic                          o_overflow;
    logic                          o_conv_drop;
    logic                          o_strm_valid;
    logic                          o_strm_overflow;
    int                            fail_count;
    int                            comparisons;
    int                            drops;
    int                            rmode;
    int                            lo;
    int                            th;
    int                            v;
    int                            cnt;

    acmt_host_model host (.i_clk(clk), .o_conv_clk(conv_clk), .o_wr_n(wr_n), .o_sel(sel));

    acmt_core #(.AW(AIN_W), .DEPTH(FIFO_DEPTH)) uut (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_conv_clk(conv_clk), .i_wr_n(wr_n), .i_channel_sel_bit2(sel[2]),
        .i_channel_sel_bit1(sel[1]), .i_channel_sel_bit0(sel[0]), .i_ain(ain),
        .i_ref_lo(ref_lo), .i_overflow_threshold(ref_hi), .o_data(o_data),
        .o_overflow(o_overflow), .o_channel(o_channel), .o_conv_drop(o_conv_drop),
        .o_strm_valid(o_strm_valid), .i_strm_ready(rdy), .o_strm_data(o_strm_data),
        .o_strm_overflow(o_strm_overflow));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Ready: random, held low, or held high
    always @(posedge clk) rdy <= (rmode == 0) ? 1'($urandom_range(0, 1)) : (rmode == 2);
    always @(posedge clk) if (o_conv_drop === 1'b1) drops++;

    // Overflow first, then below range, else highest tap not above the level
    function automatic logic [CODE_W:0] exp_word(input int a, input int l, input int t);
        int k;
        if (a >= t) return {1'b1, CODE_FULL};
        if (a < l) return {1'b0, CODE_ZERO};
        k = NUM_CODES - 1;
        while (k > 0 && l + ((t - l) * k) / NUM_CODES > a) k--;
        return {1'b0, CODE_W'(k)};
    endfunction : exp_word

    task automatic check(input logic [CODE_W:0] seen, input logic [CODE_W:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (o_strm_valid === 1'b0) return;
        end
        fail_count++;
        summarize();
    endtask : wait_idle

    initial begin
        rst_n = 1'b0;
        rmode = 0;
        ain = '0;
        ref_lo = '0;
        ref_hi = '1;
        void'($urandom(32'h0234));
        repeat (3) @(posedge clk);
        check({o_overflow, o_data}, '0);
        check({o_strm_valid, o_conv_drop, 6'h00, o_channel}, '0);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int n = 0; n < 16; n++) begin
            lo = $urandom_range(1, 1000);
            th = lo + $urandom_range(1100, 3000);
            case (n)
                0: v = lo - 1;
                1: v = lo;
                2: v = th - 1;
                3: v = th;
                4: v = 4095;
                default: v = $urandom_range(0, 4095);
            endcase
            host.write_ch(CH_W'(n));
            check({8'h00, o_channel}, CODE_W'(n % NUM_CH));
            for (int i = 0; i < NUM_CH; i++)
                ain[i] <= (i == n % NUM_CH) ? AIN_W'(v) : AIN_W'($urandom_range(0, 4095));
            ref_lo <= AIN_W'(lo);
            ref_hi <= AIN_W'(th);
            // Last sample of a pass meets new references and is not checked
            host.pulse(26 + n, 30);
            // Unchecked sample gets the shortest low time
            host.pulse(0, 30);
            check({o_overflow, o_data}, exp_word(v, lo, th));
        end
        // Fill the buffer under a stall, then drain it
        rmode = 2;
        drops = 0;
        host.pulse(30, 30);
        host.pulse(30, 30);
        wait_idle();
        rmode = 1;
        repeat (12) host.pulse(26, 26);
        check(CODE_W'(drops), CODE_W'(12 - FIFO_DEPTH - 1));
        rmode = 2;
        cnt = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (o_strm_valid === 1'b1 && rdy === 1'b1) begin
                cnt++;
                check({o_strm_overflow, o_strm_data}, exp_word(v, lo, th));
            end
        end
        check(CODE_W'(cnt), CODE_W'(FIFO_DEPTH + 1));
        wait_idle();
        summarize();
    end
endmodule : adc_sample_convert_mux_timing_tb_top
`default_nettype wire
